/* File: dv/sps_spi_partner.sv */
// behavioural spi slave trading one byte with the port in master mode
module sps_spi_partner
    import sps_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // spi lines
    input wire logic sel,
    input wire logic pol,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // bytes
    input wire sps_byte_t tx_byte,
    output sps_byte_t rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_q = 1'b0;
    logic tog_q = 1'b0;
    logic [2:0] cnt_q = 3'h0;
    wire trail = sck != sck_q && sck == pol;
    // next bit stands once the last was taken; deselected line toggles, never stale
    assign miso = sel ? tx_byte[3'h7 - cnt_q] : tog_q;
    initial rx_byte = 8'h00;
    always @(posedge clk_sys)
    begin
        sck_q <= sck;
        tog_q <= ~tog_q;
        if (!sel)
            cnt_q <= 3'h0;
        else if (trail)
        begin
            rx_byte <= {rx_byte[6:0], mosi};
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule

/* File: dv/sps_spi_port_props.sv */
// concurrent checks on the spi port pins and apb answers
`include "sps_defs.svh"
module sps_spi_port_props
#(
    parameter int ADDR_W = 12
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // core and pins
    input wire logic sleep_mode,
    input wire logic wake_req,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo_oe,
    input wire logic ss_n_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // shadow copies, so pin checks know the mode without seeing inside
    logic [7:0] ctl_q;
    logic [7:0] pin_q;
    wire wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire [7:0] idx = paddr[9:2];
    wire en = ctl_q[`SPS_CTL_EN];
    wire master = en && ctl_q[3:0] < 4'h4;
    wire gated = en && ctl_q[3:0] == 4'h4 && pin_q[`SPS_PIN_SS_DIR];
    wire mapped = paddr[1:0] == 2'b00 && idx inside {`SPS_IDX_IRQ_FLAGS, `SPS_IDX_BUFFER,
        `SPS_IDX_CONTROL, `SPS_IDX_IRQ_ENABLES, `SPS_IDX_STATUS, `SPS_IDX_PIN_CONFIG,
        `SPS_IDX_PIN_LEVELS};
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctl_q <= `SPS_CONTROL_RST;
            pin_q <= `SPS_PIN_CONFIG_RST;
        end
        else if (wr_ok && idx == `SPS_IDX_CONTROL)
            ctl_q <= pwdata[7:0];
        else if (wr_ok && idx == `SPS_IDX_PIN_CONFIG)
            pin_q <= pwdata[7:0];
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_buf_start;
        wr_ok && idx == `SPS_IDX_BUFFER && master && ctl_q[3:0] < 4'h3 && !sleep_mode;
    endsequence
    a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready is not a one cycle answer");
    a_unmapped_err: assert property (psel && penable && pready && !mapped |-> pslverr)
        else $error("unmapped access without slave error");
    a_ss_floats: assert property ((gated && ss_n_in)[*3] |-> !sdo_oe)
        else $error("serial out driven while deselected");
    a_sdo_input: assert property ((pin_q[`SPS_PIN_SDO_DIR])[*3] |-> !sdo_oe)
        else $error("serial out driven while set as input");
    a_sck_owned: assert property ((master && !pin_q[`SPS_PIN_SCK_DIR])[*3] |-> sck_oe)
        else $error("master clock pin not driven");
    a_sck_gpio: assert property ((!en && !pin_q[0] && $stable(pin_q))[*3] |->
        sck_oe && sck_out == pin_q[`SPS_PIN_SCK_LVL])
        else $error("clock pin not a general output when disabled");
    a_wake_sleep: assert property (wake_req |-> $past(sleep_mode))
        else $error("wake request outside sleep");
    a_div4_rate: assert property (master && ctl_q[3:0] == 4'h0 && $changed(sck_out)
        |=> $stable(sck_out))
        else $error("clock half period shorter than two cycles");
    a_div16_rate: assert property (master && ctl_q[3:0] == 4'h1 && $changed(sck_out)
        |=> $stable(sck_out)[*7])
        else $error("clock half period shorter than eight cycles");
    a_start_write: assert property (s_buf_start |-> ##[1:80] $changed(sck_out))
        else $error("buffer write started no clock");
    a_idle_level: assert property ((master && ctl_q[3:0] == 4'h0 && sck_oe && $stable(sck_out)
        && $stable(ctl_q))[*4] |-> sck_out == ctl_q[`SPS_CTL_POL])
        else $error("resting clock not at idle level");
endmodule
bind sps_spi_port sps_spi_port_props #(.ADDR_W(ADDR_W)) i_sps_spi_port_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .wake_req(wake_req), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdo_oe(sdo_oe), .ss_n_in(ss_n_in)
);

/* File: dv/testbench.sv */
// self-checking bench: registers, master bytes per rate, slave bytes
`include "sps_defs.svh"
module testbench
    import sps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, wake_req, miso, pol;
    logic sleep_mode = 1'b0, timer_two_tick = 1'b0;
    logic sck_out, sck_oe, sdi_out, sdi_oe, sdo_out, sdo_oe, ss_n_out, ss_n_oe;
    logic tb_sck = 1'b0, tb_sdi = 1'b0, tb_ss = 1'b0, slv = 1'b0, prt_sel = 1'b0;
    sps_byte_t prt_tx = 8'h00, prt_rx;
    int err_total = 0, samples_checked = 0, cyc = 0;
    wire sck_w = sck_oe ? sck_out : tb_sck;
    wire sdi_w = sdi_oe ? sdi_out : (slv ? tb_sdi : miso);
    wire sdo_w = sdo_oe ? sdo_out : 1'b1; // pull-up holds a floating output high
    wire ss_w = ss_n_oe ? ss_n_out : tb_ss;
    sps_spi_port i_sps_spi_port (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
        .timer_two_tick(timer_two_tick), .wake_req(wake_req), .sck_in(sck_w),
        .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_w), .sdi_out(sdi_out),
        .sdi_oe(sdi_oe), .sdo_in(sdo_w), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe));
    sps_spi_partner i_sps_spi_partner (.clk_sys(clk_sys), .sel(prt_sel), .pol(pol),
        .sck(sck_w), .mosi(sdo_w), .miso(miso), .tx_byte(prt_tx), .rx_byte(prt_rx));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        // timer pulses at least four cycles apart, so a half period never drops below the partner's lag
        timer_two_tick <= (cyc % 4 == 0) && ($urandom % 2 == 0);
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, i, {24'h000000, d}, q, e);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] m, input logic [7:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, i, 32'h0, q, e);
        chk(q & {24'h000000, m}, {24'h000000, x & m});
    endtask
    task automatic wait_bf();
        logic [31:0] q;
        logic e;
        q = 32'h0;
        for (int n = 0; n < 400 && q[0] !== 1'b1; n++)
            apb(1'b0, `SPS_IDX_STATUS, 32'h0, q, e);
        chk(q[0], 1'b1);
    endtask
    task automatic sbit(input logic b);
        tb_sdi <= b;
        tb_sck <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tb_sck <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    initial
    begin
        logic [31:0] q;
        logic e;
        logic [7:0] tx;
        void'($urandom(13364));
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(`SPS_IDX_CONTROL, 8'hFF, 8'h00);
        rd(`SPS_IDX_STATUS, 8'hFF, 8'h00);
        rd(`SPS_IDX_IRQ_FLAGS, 8'hFF, 8'h00);
        rd(`SPS_IDX_IRQ_ENABLES, 8'hFF, 8'h00);
        apb(1'b0, 8'h00, 32'h0, q, e);
        chk(e, 1'b1);
        wr(`SPS_IDX_PIN_CONFIG, 8'hF0);
        repeat (2) @(posedge clk_sys);
        chk({sck_oe, sdi_oe, sdo_oe, ss_n_oe, sck_out, sdi_out, sdo_out, ss_n_out}, 8'hFF);
        rd(`SPS_IDX_PIN_LEVELS, 8'h0F, 8'h0F);
        wr(`SPS_IDX_PIN_CONFIG, 8'h0A);
        wr(`SPS_IDX_IRQ_ENABLES, 8'h08);
        for (int m = 0; m < 4; m++)
        begin
            pol = 1'($urandom);
            tx = 8'($urandom);
            prt_tx = 8'($urandom);
            prt_sel <= 1'b0;
            wr(`SPS_IDX_CONTROL, 8'h00);
            wr(`SPS_IDX_CONTROL, {3'b001, pol, 4'(m)});
            repeat (3) @(posedge clk_sys);
            prt_sel <= 1'b1;
            wr(`SPS_IDX_BUFFER, tx);
            if (m == 0)
            begin
                wr(`SPS_IDX_BUFFER, ~tx);
                rd(`SPS_IDX_CONTROL, 8'h80, 8'h80);
                wr(`SPS_IDX_CONTROL, {3'b001, pol, 4'h0});
                rd(`SPS_IDX_CONTROL, 8'h80, 8'h00);
            end
            wait_bf();
            chk(sck_w, pol);
            rd(`SPS_IDX_IRQ_FLAGS, 8'h08, 8'h08);
            rd(`SPS_IDX_BUFFER, 8'hFF, prt_tx);
            chk(prt_rx, tx);
            rd(`SPS_IDX_STATUS, 8'h01, 8'h00);
            wr(`SPS_IDX_IRQ_FLAGS, 8'h00);
        end
        prt_sel <= 1'b0;
        slv <= 1'b1;
        sleep_mode <= 1'b1;
        wr(`SPS_IDX_PIN_CONFIG, 8'h0B);
        wr(`SPS_IDX_CONTROL, 8'h00);
        wr(`SPS_IDX_CONTROL, 8'h25);
        tx = 8'($urandom);
        for (int i = 7; i >= 0; i--)
            sbit(tx[i]);
        rd(`SPS_IDX_IRQ_FLAGS, 8'h08, 8'h08);
        chk(wake_req, 1'b1);
        for (int i = 7; i >= 0; i--)
            sbit(~tx[i]);
        rd(`SPS_IDX_CONTROL, 8'h40, 8'h40);
        rd(`SPS_IDX_BUFFER, 8'hFF, tx);
        wr(`SPS_IDX_CONTROL, 8'h00);
        wr(`SPS_IDX_CONTROL, 8'h24);
        tb_ss <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(sdo_oe, 1'b0);
        tb_ss <= 1'b0;
        tx = 8'($urandom);
        for (int i = 7; i >= 4; i--)
            sbit(tx[i]);
        chk(sdo_oe, 1'b1);
        tb_ss <= 1'b1;
        for (int i = 0; i < 3; i++)
            sbit(~tx[3]);
        tb_ss <= 1'b0;
        for (int i = 3; i >= 0; i--)
            sbit(tx[i]);
        rd(`SPS_IDX_BUFFER, 8'hFF, tx);
        wr(`SPS_IDX_PIN_CONFIG, 8'h0F);
        repeat (3) @(posedge clk_sys);
        chk(sdo_oe, 1'b0);
        // master with its clock pin an input keeps sampling and restarting
        sleep_mode <= 1'b0;
        tb_sdi <= 1'b1;
        wr(`SPS_IDX_CONTROL, 8'h00);
        wr(`SPS_IDX_CONTROL, 8'h20);
        wr(`SPS_IDX_BUFFER, 8'h00);
        wait_bf();
        rd(`SPS_IDX_BUFFER, 8'hFF, 8'hFF);
        wait_bf();
        rd(`SPS_IDX_BUFFER, 8'hFF, 8'hFF);
        finish_test();
    end
endmodule

/* File: rtl/sps_defs.svh */
// register indices, field positions, reset values and rate counts
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// register indices; byte address is four times the index
`define SPS_IDX_IRQ_FLAGS 8'h0C
`define SPS_IDX_BUFFER 8'h13
`define SPS_IDX_CONTROL 8'h14
`define SPS_IDX_IRQ_ENABLES 8'h8C
`define SPS_IDX_STATUS 8'h94
`define SPS_IDX_PIN_CONFIG 8'hA0
`define SPS_IDX_PIN_LEVELS 8'hA1

// serial_port_control fields
`define SPS_CTL_WRITE_COLLISION 7
`define SPS_CTL_OVF 6
`define SPS_CTL_EN 5
`define SPS_CTL_POL 4

// serial_port_status and irq fields
`define SPS_STAT_BF 0
`define SPS_IRQ_XFER 3

// pin_config fields: direction (1 = input) and general output level
`define SPS_PIN_SCK_DIR 0
`define SPS_PIN_SDI_DIR 1
`define SPS_PIN_SDO_DIR 2
`define SPS_PIN_SS_DIR 3
`define SPS_PIN_SCK_LVL 4
`define SPS_PIN_SDI_LVL 5
`define SPS_PIN_SDO_LVL 6
`define SPS_PIN_SS_LVL 7

// reset values
`define SPS_CONTROL_RST 8'h00
`define SPS_STATUS_RST 1'b0
`define SPS_IRQ_RST 1'b0
`define SPS_PIN_CONFIG_RST 8'h0F

// half bit periods in clk_sys cycles for the fixed master rates, and the index of the last bit of a byte
`define SPS_HALF_DIV4 6'h02
`define SPS_HALF_DIV16 6'h08
`define SPS_HALF_DIV64 6'h20
`define SPS_BYTE_LAST 4'h7

`endif

/* File: rtl/sps_pkg.sv */
// types shared by the serial port modules
package sps_pkg;
    typedef enum logic [3:0] {
        MODE_MASTER_DIV4 = 4'b0000,
        MODE_MASTER_DIV16 = 4'b0001,
        MODE_MASTER_DIV64 = 4'b0010,
        MODE_MASTER_TIMER = 4'b0011,
        MODE_SLAVE_SEL = 4'b0100,
        MODE_SLAVE = 4'b0101
    } sps_mode_e;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } sps_state_e;
    typedef logic [7:0] sps_byte_t;
endpackage

/* File: rtl/sps_rate_gen.sv */
// master bit clock half period generator
module sps_rate_gen
    import sps_pkg::*;
#(
    parameter int CNT_W = 6
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // rate request
    sps_rate_if.gen rate
);
`include "sps_defs.svh"

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] limit;
    logic tick_q;
    logic tick_d;

    // fixed rates count clk_sys, the timer rate halves the timer output
    assign limit = (rate.rate_sel == 2'b00) ? CNT_W'(`SPS_HALF_DIV4 - 6'h01) :
                   (rate.rate_sel == 2'b01) ? CNT_W'(`SPS_HALF_DIV16 - 6'h01) :
                   CNT_W'(`SPS_HALF_DIV64 - 6'h01);

    always_comb
    begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!rate.run)
        begin
            cnt_d = '0;
        end
        else if (rate.rate_sel == 2'b11)
        begin
            tick_d = rate.timer_tick;
        end
        else if (cnt_q == limit)
        begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign rate.half_tick = tick_q;
endmodule

/* File: rtl/sps_rate_if.sv */
// bit rate request and half period tick between port and rate generator
interface sps_rate_if;
    logic run;
    logic [1:0] rate_sel;
    logic timer_tick;
    logic half_tick;
    modport ctrl (output run, output rate_sel, output timer_tick, input half_tick);
    modport gen (input run, input rate_sel, input timer_tick, output half_tick);
endinterface

/* File: rtl/sps_spi_port.sv */
// synchronous serial port in spi mode with an apb register slave
// What this block does
// - shift register reached only through buffer
// - enabled port owns pins unless direction overrides
// - master starts byte on buffer write
// - master keeps receiving with clock pin input
// - slave shifts on external clock, flags byte
// - drive on one edge, sample on other
// - polarity sets idle level; msb first
// - master rate div4, div16, div64, timer/2
// - slave works in sleep, may wake core
// - low select shifts; high select floats output
// - reselect resumes byte where it stopped
// - output pin as input stops transmission
// - full byte moves to buffer, sets flags
// - buffer write while busy ignored, sets collision
// - buffer read clears buffer full
// - slave byte onto unread buffer sets overflow
module sps_spi_port
    import sps_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core
    input wire logic sleep_mode,
    input wire logic timer_two_tick,
    output logic wake_req,
    // serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // serial in pin
    input wire logic sdi_in,
    output logic sdi_out,
    output logic sdi_oe,
    // serial out pin
    input wire logic sdo_in,
    output logic sdo_out,
    output logic sdo_oe,
    // slave select pin
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe
);
`include "sps_defs.svh"

    function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] target);
        return idx == target;
    endfunction

    sps_rate_if rate ();

    sps_rate_gen #(
        .CNT_W(6)
    ) u_rate (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .rate(rate)
    );

    // register state
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] pin_q;
    sps_byte_t buf_q;
    sps_byte_t buf_d;
    logic bf_q;
    logic flag_q;
    logic irq_en_q;
    // shifter state
    sps_byte_t sr_q;
    sps_byte_t sr_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    sps_state_e state_q;
    sps_state_e state_d;
    logic sck_q;
    logic sck_d;
    logic sdo_q;
    logic sck_prev_q;
    // bus answer and pin outputs
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic wake_q;
    logic sck_out_q;
    logic sck_oe_q;
    logic sdi_out_q;
    logic sdi_oe_q;
    logic sdo_out_q;
    logic sdo_oe_q;
    logic ss_n_out_q;
    logic ss_n_oe_q;

    // bus decode
    wire [7:0] idx = paddr[9:2];
    wire aligned = paddr[1:0] == 2'b00;
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_q;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire hit_flags = aligned & reg_hit(idx, `SPS_IDX_IRQ_FLAGS);
    wire hit_buf = aligned & reg_hit(idx, `SPS_IDX_BUFFER);
    wire hit_ctl = aligned & reg_hit(idx, `SPS_IDX_CONTROL);
    wire hit_en = aligned & reg_hit(idx, `SPS_IDX_IRQ_ENABLES);
    wire hit_stat = aligned & reg_hit(idx, `SPS_IDX_STATUS);
    wire hit_pin = aligned & reg_hit(idx, `SPS_IDX_PIN_CONFIG);
    wire hit_lvl = aligned & reg_hit(idx, `SPS_IDX_PIN_LEVELS);
    wire mapped = hit_flags | hit_buf | hit_ctl | hit_en | hit_stat | hit_pin | hit_lvl;
    wire buf_wr = wr & hit_buf;
    wire buf_rd = rd & hit_buf;

    // mode decode
    wire en = ctl_q[`SPS_CTL_EN];
    wire pol = ctl_q[`SPS_CTL_POL];
    wire [3:0] mode = ctl_q[3:0];
    wire is_master = en & (mode <= MODE_MASTER_TIMER);
    wire is_slave = en & ((mode == MODE_SLAVE_SEL) | (mode == MODE_SLAVE));
    wire gated = is_slave & (mode == MODE_SLAVE_SEL) & pin_q[`SPS_PIN_SS_DIR];
    wire deselected = gated & ss_n_in;
    wire monitor = is_master & pin_q[`SPS_PIN_SCK_DIR];
    wire shifting = state_q == ST_SHIFT;

    // master edges come from the rate tick; leaving idle is the drive edge
    wire m_tick = is_master & shifting & rate.half_tick;
    wire m_tx = m_tick & (sck_q == pol);
    wire m_rx = m_tick & (sck_q != pol);
    // slave edges from the pin; a deselected slave holds its bit position
    wire s_away = (sck_prev_q == pol) & (sck_in != pol);
    wire s_back = (sck_prev_q != pol) & (sck_in == pol);
    wire s_tx = is_slave & ~deselected & s_away;
    wire s_rx = is_slave & ~deselected & s_back;
    wire tx_edge = m_tx | s_tx;
    wire rx_edge = m_rx | s_rx;
    wire done = rx_edge & (cnt_q == `SPS_BYTE_LAST);
    sps_byte_t sr_next;
    assign sr_next = {sr_q[6:0], sdi_in};

    // busy covers a master byte in flight or a slave byte part way through
    wire busy = is_master ? shifting : (cnt_q != 4'h0);
    wire load_ok = buf_wr & en & ~busy;
    wire collide = buf_wr & en & busy;
    wire ovf = is_slave & done & bf_q & ~buf_rd;
    wire store = done & ~ovf;

    assign rate.run = is_master & shifting & ~sleep_mode;
    assign rate.rate_sel = mode[1:0];
    assign rate.timer_tick = timer_two_tick;

    // control: hardware set of collision and overflow wins over a clear
    always_comb
    begin
        ctl_d = hit_ctl & wr ? pwdata[7:0] : ctl_q;
        ctl_d[`SPS_CTL_WRITE_COLLISION] = collide | ctl_d[`SPS_CTL_WRITE_COLLISION];
        ctl_d[`SPS_CTL_OVF] = ovf | ctl_d[`SPS_CTL_OVF];
    end

    // buffer: written value held for readback, received byte replaces it
    always_comb
    begin
        buf_d = buf_q;
        if (store)
        begin
            buf_d = sr_next;
        end
        else if (buf_wr & ~collide)
        begin
            buf_d = pwdata[7:0];
        end
    end

    // shifter: disabling the port drops a partial byte
    always_comb
    begin
        sr_d = sr_q;
        cnt_d = cnt_q;
        state_d = state_q;
        if (!(is_master | is_slave))
        begin
            cnt_d = 4'h0;
            state_d = ST_IDLE;
        end
        else if (load_ok)
        begin
            sr_d = pwdata[7:0];
            cnt_d = 4'h0;
            state_d = is_master ? ST_SHIFT : ST_IDLE;
        end
        else if (rx_edge)
        begin
            sr_d = sr_next;
            cnt_d = done ? 4'h0 : cnt_q + 4'h1;
            if (done & ~monitor)
            begin
                state_d = ST_IDLE;
            end
        end
    end

    // master clock level: idle at the polarity level unless a byte runs
    always_comb
    begin
        sck_d = sck_q;
        if (!is_master || !shifting)
        begin
            sck_d = pol;
        end
        else if (m_tick)
        begin
            sck_d = ~sck_q;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctl_q <= `SPS_CONTROL_RST;
            pin_q <= `SPS_PIN_CONFIG_RST;
            bf_q <= `SPS_STATUS_RST;
            flag_q <= `SPS_IRQ_RST;
            irq_en_q <= `SPS_IRQ_RST;
        end
        else
        begin
            ctl_q <= ctl_d;
            pin_q <= hit_pin & wr ? pwdata[7:0] : pin_q;
            bf_q <= store | (bf_q & ~buf_rd);
            flag_q <= done | (hit_flags & wr ? pwdata[`SPS_IRQ_XFER] : flag_q);
            irq_en_q <= hit_en & wr ? pwdata[`SPS_IRQ_XFER] : irq_en_q;
        end
    end

    // buffer has no reset: unknown at power on, kept over resets
    always_ff @(posedge clk_sys)
    begin
        buf_q <= buf_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sr_q <= 8'h00;
            cnt_q <= 4'h0;
            state_q <= ST_IDLE;
            sck_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end
        else
        begin
            sr_q <= sr_d;
            cnt_q <= cnt_d;
            state_q <= state_d;
            sck_q <= sck_d;
            sck_prev_q <= sck_in;
        end
    end

    // the msb leaves first, on the edge away from idle
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sdo_q <= 1'b0;
        end
        else if (tx_edge)
        begin
            sdo_q <= sr_q[7];
        end
    end

    // read data mux; status and pin levels are read only
    logic [7:0] rdata;
    always_comb
    begin
        rdata = 8'h00;
        if (hit_flags)
        begin
            rdata[`SPS_IRQ_XFER] = flag_q;
        end
        if (hit_en)
        begin
            rdata[`SPS_IRQ_XFER] = irq_en_q;
        end
        if (hit_stat)
        begin
            rdata[`SPS_STAT_BF] = bf_q;
        end
        if (hit_buf)
        begin
            rdata = buf_q;
        end
        if (hit_ctl)
        begin
            rdata = ctl_q;
        end
        if (hit_pin)
        begin
            rdata = pin_q;
        end
        if (hit_lvl)
        begin
            rdata = {4'h0, ss_n_in, sdo_in, sdi_in, sck_in};
        end
    end

    // answer is registered, so every access phase ends in its first cycle
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= setup ? {24'h000000, rdata} : prdata_q;
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
        end
    end

    // pins: serial function only where the direction bit agrees with it;
    // outputs are registered, so a select release floats the pin one cycle late
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sck_out_q <= 1'b0;
            sck_oe_q <= 1'b0;
            sdi_out_q <= 1'b0;
            sdi_oe_q <= 1'b0;
            sdo_out_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            ss_n_out_q <= 1'b0;
            ss_n_oe_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            sck_out_q <= is_master ? sck_q : pin_q[`SPS_PIN_SCK_LVL];
            sck_oe_q <= ~pin_q[`SPS_PIN_SCK_DIR];
            sdi_out_q <= pin_q[`SPS_PIN_SDI_LVL];
            sdi_oe_q <= ~pin_q[`SPS_PIN_SDI_DIR];
            sdo_out_q <= en ? sdo_q : pin_q[`SPS_PIN_SDO_LVL];
            sdo_oe_q <= ~pin_q[`SPS_PIN_SDO_DIR] & ~deselected;
            ss_n_out_q <= pin_q[`SPS_PIN_SS_LVL];
            ss_n_oe_q <= ~pin_q[`SPS_PIN_SS_DIR];
            wake_q <= sleep_mode & flag_q & irq_en_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign wake_req = wake_q;
    assign sck_out = sck_out_q;
    assign sck_oe = sck_oe_q;
    assign sdi_out = sdi_out_q;
    assign sdi_oe = sdi_oe_q;
    assign sdo_out = sdo_out_q;
    assign sdo_oe = sdo_oe_q;
    assign ss_n_out = ss_n_out_q;
    assign ss_n_oe = ss_n_oe_q;
endmodule
